// *** mcgc_top.sv ***
// Summary of operation
// - Detected error raises abort-class machine check
// - Detect bus, ECC, parity, cache, TLB errors
// - Each unit hits bank (kind mod bank count); with 4 banks TLB shares bank 0 with bus
// - Capability low byte reports bank count
// - Bit 8 set when enable register exists
// - Bit 9 set only if extended registers exist
// - Bits 16-23 give extended register count
// - Capability reserved bits zero, writes ignored
// - Legacy capability keeps only count, bit 8
// - Restart pointer flag set when resumable
// - Error pointer flag set when instruction linked
// - Check-in-progress set on exception, software-writable
// - Second event while in progress causes shutdown
// - Global state bits 3-63 reserved
// - Enable register only when present flag set
// - All ones enables, all zeros disables
// - Other enable values: any one bit set enables
// - Legacy mode logs type, address before exception
`timescale 1ns/1ps
module mcgc_top
  import mcgc_pkg::*;
#(
  parameter int          NBANK      = 4,      // Banks implemented
  parameter bit          CTL_PRESENT = 1'b1,  // Enable register implemented
  parameter bit          EXT_PRESENT = 1'b0,  // Extended state implemented
  parameter logic [7:0]  EXT_COUNT  = 8'h00,  // Extended register count
  parameter bit          LEGACY_CAP = 1'b0    // Older capability layout
)
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [NUM_SRC-1:0] err_src,
  input  wire logic              err_restartable,
  input  wire logic              err_ip_linked,
  input  wire logic              legacy_mode,
  input  wire logic              legacy_read_parity,
  input  wire logic              legacy_bus_fail,
  input  wire logic [63:0]       legacy_addr_in,
  input  wire logic              msr_rd,
  input  wire logic              msr_wr,
  input  wire logic [1:0]        msr_sel,
  input  wire logic [63:0]       msr_wdata,
  output logic [63:0]            msr_rdata,
  output logic                   msr_fault,
  output logic                   machine_check_abort,
  output logic                   shutdown,
  output logic [1:0]             legacy_error_type,
  output logic [63:0]            legacy_error_address
);
  // Reset and error paths
  logic             rst_n;            // Synchronised reset
  logic [NBANK-1:0] bank_hit;         // Banks reporting this cycle
  logic             any_err;          // Any enabled-source error
  logic             legacy_err;       // Legacy-class error
  logic             event_req;        // Machine-check event request
  logic             features_on;      // Global enable in force
  // Register file and machine-check flags
  logic [63:0]      enable_q;         // Global enable register
  logic             restart_ptr_valid_q;           // Restart pointer valid
  logic             error_ptr_valid_q;           // Error pointer valid
  logic             check_in_progress_q;           // Check in progress
  logic             abort_q;          // Abort pulse register
  logic             legacy_pend_q;    // Legacy log done, raise next
  // Read path, control state and strobes
  logic [63:0]      cap_value;        // Capability read value
  logic [63:0]      rdata_d;          // Read data next
  mcgc_state_t      state_q;          // Control state
  mcgc_state_t      state_d;          // Control state next
  logic             st_wr;            // Software write of global state
  logic             en_wr;            // Software write of enable

  // An event becomes an abort only from run with no check pending;
  // shared by the pulse and the flag capture so both agree on one cycle
  function automatic logic take_abort
  (
    input mcgc_state_t st,
    input logic        ev,
    input logic        busy
  );
    return (st == MCGC_RUN) && ev && !busy;
  endfunction

  // Register select decode, shared by the strobes and the fault
  function automatic logic sel_hit
  (
    input logic [1:0] sel,
    input logic [1:0] which
  );
    return (sel == which);
  endfunction

  // Reset release
  mcgc_rst_sync u_rst_sync
  (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .rst_n_sync (rst_n)
  );

  // Error source collection; banks are not masked here,
  // the global enable gates the combined event instead
  mcgc_err_collect #(.NBANK(NBANK)) u_err_collect
  (
    .err_src      (err_src),
    .src_bank_sel ({NBANK{1'b1}}),
    .bank_hit     (bank_hit),
    .any_err      (any_err)
  );

  // Enable in force: without the register, checking is always on
  always_comb
  begin
    // Register built: all ones arms, all zeros disarms, any set bit arms
    if (CTL_PRESENT)
      features_on = |enable_q;
    // Register absent: nothing can disarm the checks
    else
      features_on = 1'b1;
  end

  // Legacy errors logged first, exception raised one cycle later
  assign legacy_err = legacy_mode && (legacy_read_parity || legacy_bus_fail);

  // A machine-check event, from either path; core sources are masked in
  // legacy mode so one fault is never reported twice
  assign event_req = features_on && ((any_err && !legacy_mode) || legacy_pend_q);

  // Software write strobes
  assign st_wr = msr_wr && sel_hit(msr_sel, REG_STATE);
  // Enable writes are dropped when the register is not built
  assign en_wr = msr_wr && sel_hit(msr_sel, REG_ENABLE) && CTL_PRESENT;

  // Capability value from build options
  always_comb
  begin
    // Reserved bits stay clear; writes never reach this word
    cap_value = 64'h0;
    // Bank count and enable-present flag exist in both layouts
    cap_value[CAP_COUNT_LSB +: 8] = 8'(NBANK);
    cap_value[CAP_CTL_P_BIT] = CTL_PRESENT;
    // Extended layout adds the extended-state flag and its count
    if (!LEGACY_CAP)
    begin
      cap_value[CAP_EXT_P_BIT] = EXT_PRESENT;
      cap_value[CAP_EXT_LSB +: 8] = EXT_PRESENT ? EXT_COUNT : 8'h00;
    end
    // Legacy layout keeps bits 9 and up clear
    else
    begin
      cap_value[63:9] = 55'h0;
    end
  end

  // Control state next
  always_comb
  begin
    // Hold by default; run leaves only on an event, abort always leaves
    state_d = state_q;
    unique case (state_q)
      MCGC_RUN:
      begin
        // An event while a check is still pending shuts the core down
        if (event_req)
          state_d = check_in_progress_q ? MCGC_SHUTDOWN : MCGC_ABORT;
      end
      MCGC_ABORT:
      begin
        // Abort taken; a further event in this cycle shuts the core down
        if (event_req)
          state_d = MCGC_SHUTDOWN;
        // Quiet cycle: back to run, the pending flag guards the rest
        else
          state_d = MCGC_RUN;
      end
      MCGC_SHUTDOWN:
      begin
        state_d = MCGC_SHUTDOWN; // Held until reset
      end
      default:
      begin
        // Illegal code: fail safe into shutdown
        state_d = MCGC_SHUTDOWN;
      end
    endcase
  end

  // Control state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    // Reset returns to run
    if (!rst_n)
      state_q <= MCGC_RUN;
    else
      state_q <= state_d;
  end

  // Abort pulse, one cycle per accepted event; the state leaves run on
  // the same edge, so the pulse cannot stretch
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      abort_q <= 1'b0;
    else
      abort_q <= take_abort(state_q, event_req, check_in_progress_q);
  end

  // Global state flags; hardware set wins over software write
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // All three flags clear out of reset
      {check_in_progress_q, error_ptr_valid_q, restart_ptr_valid_q} <= STATE_RESET;
    end
    // Hardware capture of the event context
    else if (take_abort(state_q, event_req, check_in_progress_q))
    begin
      restart_ptr_valid_q <= err_restartable;
      error_ptr_valid_q <= err_ip_linked;
      check_in_progress_q <= 1'b1;
    end
    // Software may set or clear any flag
    else if (st_wr)
    begin
      restart_ptr_valid_q <= msr_wdata[ST_RESTART_PTR_VALID_BIT];
      error_ptr_valid_q <= msr_wdata[ST_ERROR_PTR_VALID_BIT];
      check_in_progress_q <= msr_wdata[ST_CHECK_IN_PROGRESS_BIT];
    end
  end

  // Global enable register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    // With the register built, checking stays off until software arms it
    if (!rst_n)
      enable_q <= ENABLE_RESET;
    // Any value is stored and read back; only the armed test acts on it
    else if (en_wr)
      enable_q <= msr_wdata;
  end

  // Legacy log: type and address captured before the exception
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Log empty after reset
      legacy_error_type    <= LTYPE_RESET;
      legacy_error_address <= LADDR_RESET;
      legacy_pend_q        <= 1'b0;
    end
    else
    begin
      // Exception request follows one cycle after the log, only when armed
      legacy_pend_q <= legacy_err && features_on;
      // Parity takes the type code when both report at once
      if (legacy_err)
      begin
        legacy_error_type    <= legacy_read_parity ? LTYPE_READ_PARITY : LTYPE_BUS_FAIL;
        legacy_error_address <= legacy_addr_in;
      end
    end
  end

  // Read mux
  always_comb
  begin
    // Default keeps the read path free of latches
    rdata_d = 64'h0;
    unique case (msr_sel)
      REG_CAP:    rdata_d = cap_value;
      REG_STATE:  rdata_d = {61'h0, check_in_progress_q, error_ptr_valid_q, restart_ptr_valid_q};
      REG_ENABLE: rdata_d = CTL_PRESENT ? enable_q : 64'h0;
      // Legacy log packs the address above the type code
      REG_LEGACY: rdata_d = {legacy_error_address[61:0], legacy_error_type};
    endcase
  end

  // Read data and fault registered
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Bus outputs quiet in reset
      msr_rdata <= RDATA_RESET;
      msr_fault <= 1'b0;
    end
    else
    begin
      // Read data holds until the next read
      if (msr_rd)
        msr_rdata <= rdata_d;
      // Absent enable register faults on access
      msr_fault <= (msr_rd || msr_wr) && sel_hit(msr_sel, REG_ENABLE) && !CTL_PRESENT;
    end
  end

  // Abort pulse and shutdown level to the core
  assign machine_check_abort = abort_q;
  assign shutdown = (state_q == MCGC_SHUTDOWN);
endmodule // mcgc_top

// *** mcgc_pkg.sv ***
package mcgc_pkg;
  // Register selects on the model-specific register port
  localparam logic [1:0] REG_CAP       = 2'h0;
  localparam logic [1:0] REG_STATE     = 2'h1;
  localparam logic [1:0] REG_ENABLE    = 2'h2;
  localparam logic [1:0] REG_LEGACY    = 2'h3;
  // Capability field positions
  localparam int CAP_COUNT_LSB  = 0;
  localparam int CAP_CTL_P_BIT  = 8;
  localparam int CAP_EXT_P_BIT  = 9;
  localparam int CAP_EXT_LSB    = 16;
  // Base address of extended state registers
  localparam logic [31:0] EXT_STATE_BASE = 32'h0000_0180;
  // Global state field positions
  localparam int ST_RESTART_PTR_VALID_BIT = 0;
  localparam int ST_ERROR_PTR_VALID_BIT = 1;
  localparam int ST_CHECK_IN_PROGRESS_BIT = 2;
  // Reset values
  localparam logic [63:0] ENABLE_RESET = 64'h0;
  localparam logic [2:0]  STATE_RESET  = 3'h0;
  localparam logic [1:0]  LTYPE_RESET  = 2'h0;
  localparam logic [63:0] LADDR_RESET  = 64'h0;
  localparam logic [63:0] RDATA_RESET  = 64'h0;
  // Error source kinds
  localparam int SRC_BUS    = 0;
  localparam int SRC_ECC    = 1;
  localparam int SRC_PARITY = 2;
  localparam int SRC_CACHE  = 3;
  localparam int SRC_TLB    = 4;
  localparam int NUM_SRC    = 5;
  // Legacy error type codes
  localparam logic [1:0] LTYPE_READ_PARITY = 2'h1;
  localparam logic [1:0] LTYPE_BUS_FAIL    = 2'h2;

  // Control flow states
  typedef enum logic [2:0] {
    MCGC_RUN      = 3'b001,
    MCGC_ABORT    = 3'b010,
    MCGC_SHUTDOWN = 3'b100
  } mcgc_state_t;

  // All-ones test on enable value
  function automatic logic mcgc_all_ones(input logic [63:0] v);
    return &v;
  endfunction
endpackage

// *** mcgc_rst_sync.sv ***
`timescale 1ns/1ps
module mcgc_rst_sync
  import mcgc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  output logic      rst_n_sync
);
  logic s1_q;  // First stage
  logic s2_q;  // Second stage

  // Two-flop release of reset
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end
    else
    begin
      s1_q <= 1'b1;
      s2_q <= s1_q;
    end
  end

  assign rst_n_sync = s2_q;
endmodule // mcgc_rst_sync

// *** mcgc_err_collect.sv ***
`timescale 1ns/1ps
module mcgc_err_collect
  import mcgc_pkg::*;
#(
  parameter int NBANK = 4
)
(
  input  wire logic [NUM_SRC-1:0] err_src,
  input  wire logic [NBANK-1:0]   src_bank_sel,
  output logic [NBANK-1:0]        bank_hit,
  output logic                    any_err
);
  // Each unit reports through bank (kind mod NBANK); with 4 banks TLB shares bank 0 with bus
  always_comb
  begin
    bank_hit = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (err_src[i])
      begin
        bank_hit[i % NBANK] = 1'b1;
      end
    end
    bank_hit = bank_hit & src_bank_sel;
    any_err  = |bank_hit;
  end
endmodule // mcgc_err_collect

// *** mcgc_props.sv ***
`timescale 1ns/1ps
module mcgc_props
  import mcgc_pkg::*;
#(
  parameter int         NBANK       = 4,
  parameter bit         CTL_PRESENT = 1'b1,
  parameter bit         EXT_PRESENT = 1'b0,
  parameter logic [7:0] EXT_COUNT   = 8'h00,
  parameter bit         LEGACY_CAP  = 1'b0
)
(
  input wire logic               sys_clk,
  input wire logic               nrst,
  input wire logic [NUM_SRC-1:0] err_src,
  input wire logic               legacy_read_parity,
  input wire logic               legacy_bus_fail,
  input wire logic               msr_rd,
  input wire logic               msr_wr,
  input wire logic [1:0]         msr_sel,
  input wire logic [63:0]        msr_rdata,
  input wire logic               msr_fault,
  input wire logic               machine_check_abort,
  input wire logic               shutdown
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Capability word for the chosen layout
  localparam logic [63:0] CAP_EXP = LEGACY_CAP ? {55'h0, CTL_PRESENT, 8'(NBANK)}
    : {40'h0, EXT_COUNT, 6'h00, EXT_PRESENT, CTL_PRESENT, 8'(NBANK)};
  // Read request steps
  sequence s_cap_rd;
    msr_rd && msr_sel == REG_CAP;
  endsequence
  sequence s_state_rd;
    msr_rd && msr_sel == REG_STATE;
  endsequence
  a_cap_value: assert property (s_cap_rd |=> msr_rdata == CAP_EXP)
    else $error("capability read value wrong");
  a_state_rsv: assert property (s_state_rd |=> msr_rdata[63:3] == 61'h0)
    else $error("global state reserved bits set");
  a_abort_pulse: assert property (machine_check_abort |=> !machine_check_abort)
    else $error("abort longer than one cycle");
  a_abort_cause: assert property ($rose(machine_check_abort) |-> $past(|err_src) || $past(legacy_read_parity || legacy_bus_fail, 2))
    else $error("abort without an error event");
  a_shut_sticky: assert property (shutdown |=> shutdown)
    else $error("shutdown left without reset");
  a_shut_quiet: assert property (shutdown |-> !machine_check_abort)
    else $error("abort raised in shutdown");
  a_enable_ok: assert property ((msr_rd || msr_wr) && msr_sel == REG_ENABLE && CTL_PRESENT |=> !msr_fault)
    else $error("fault on present enable register");
  a_legacy_gap: assert property ($rose(legacy_read_parity) && !(|err_src) |=> !machine_check_abort)
    else $error("legacy abort before logging");
endmodule // mcgc_props

bind mcgc_top mcgc_props #(.NBANK(NBANK), .CTL_PRESENT(CTL_PRESENT), .EXT_PRESENT(EXT_PRESENT),
  .EXT_COUNT(EXT_COUNT), .LEGACY_CAP(LEGACY_CAP)) u_props (.sys_clk, .nrst, .err_src, .legacy_read_parity,
  .legacy_bus_fail, .msr_rd, .msr_wr, .msr_sel, .msr_rdata, .msr_fault, .machine_check_abort, .shutdown);

// *** mcgc_err_model.sv ***
`timescale 1ns/1ps
module mcgc_err_model
  import mcgc_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          go,     // Raise one event
  input  wire logic [2:0]    kind,   // 0-4 core kinds, 5 parity, 6 bus
  input  wire logic          rs,     // Event restartable
  input  wire logic          lk,     // Event tied to instruction
  output logic [NUM_SRC-1:0] err_src,
  output logic               err_restartable,
  output logic               err_ip_linked,
  output logic               legacy_read_parity,
  output logic               legacy_bus_fail
);
  // One-cycle event; released qualifiers flip
  always_ff @(posedge sys_clk)
  begin
    err_src            <= (go && kind < 3'h5) ? 5'(1 << kind) : 5'h00;
    legacy_read_parity <= go && kind == 3'h5;
    legacy_bus_fail    <= go && kind == 3'h6;
    err_restartable    <= go ? rs : !err_restartable;
    err_ip_linked      <= go ? lk : !err_ip_linked;
  end
endmodule // mcgc_err_model

// *** machine_check_global_control_tb.sv ***
`timescale 1ns/1ps
module machine_check_global_control_tb;
  import mcgc_pkg::*;
  localparam logic [63:0] CAP_EXP = {40'h0, 8'h05, 6'h00, 1'b1, 1'b1, 8'h04};
  localparam logic [63:0] ONES    = 64'hFFFF_FFFF_FFFF_FFFF;
  logic               sys_clk, nrst, legacy_mode, msr_rd, msr_wr, go, rs, lk, seen;
  logic               err_restartable, err_ip_linked, legacy_read_parity, legacy_bus_fail;
  logic               msr_fault, machine_check_abort, shutdown;
  logic [2:0]         kind;
  logic [1:0]         msr_sel, legacy_error_type;
  logic [63:0]        msr_wdata, msr_rdata, legacy_addr_in, legacy_error_address;
  logic [NUM_SRC-1:0] err_src;
  int                 n_fail, total_checks;

  mcgc_top #(.EXT_PRESENT(1'b1), .EXT_COUNT(8'h05)) dut (.sys_clk, .nrst, .err_src, .err_restartable,
    .err_ip_linked, .legacy_mode, .legacy_read_parity, .legacy_bus_fail, .legacy_addr_in, .msr_rd, .msr_wr,
    .msr_sel, .msr_wdata, .msr_rdata, .msr_fault, .machine_check_abort, .shutdown, .legacy_error_type,
    .legacy_error_address);
  mcgc_err_model u_model (.sys_clk, .go, .kind, .rs, .lk, .err_src, .err_restartable, .err_ip_linked,
    .legacy_read_parity, .legacy_bus_fail);

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register read, data one cycle later
  task automatic rd(input logic [1:0] s, output logic [63:0] v);
    @(posedge sys_clk);
    msr_rd  <= 1'b1;
    msr_sel <= s;
    @(posedge sys_clk);
    msr_rd  <= 1'b0;
    #1 v = msr_rdata;
  endtask

  task automatic wr(input logic [1:0] s, input logic [63:0] d);
    @(posedge sys_clk);
    msr_wr    <= 1'b1;
    msr_sel   <= s;
    msr_wdata <= d;
    @(posedge sys_clk);
    msr_wr    <= 1'b0;
  endtask

  // One event, then watch four cycles for the abort
  task automatic fire(input logic [2:0] k, input logic r, input logic l);
    @(posedge sys_clk);
    go   <= 1'b1;
    kind <= k;
    rs   <= r;
    lk   <= l;
    @(posedge sys_clk);
    go   <= 1'b0;
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge sys_clk);
      #1 seen = seen | machine_check_abort;
    end
  endtask

  task automatic t_after_reset;
    logic [63:0] v;
    rd(REG_STATE, v);
    chk("state", 64'h0, v);
    wr(REG_CAP, 64'h0);
    rd(REG_CAP, v);
    chk("capability", CAP_EXP, v);
    fire(3'h0, 1'b1, 1'b1);
    chk("abort disabled", 64'h0, 64'(seen));
  endtask

  task automatic t_each_kind;
    logic [63:0] v;
    wr(REG_ENABLE, ONES);
    rd(REG_ENABLE, v);
    chk("enable", ONES, v);
    chk("enable fault", 64'h0, 64'(msr_fault));
    for (int k = 0; k < NUM_SRC; k++)
    begin
      fire(3'(k), k[0], k[1]);
      chk("abort", 64'h1, 64'(seen));
      rd(REG_STATE, v);
      chk("state", {61'h0, 1'b1, k[1], k[0]}, v);
      wr(REG_STATE, 64'h0);
    end
  endtask

  task automatic t_legacy;
    logic [63:0] v;
    legacy_mode <= 1'b1;
    fire(3'h5, 1'b0, 1'b0);
    chk("legacy abort", 64'h1, 64'(seen));
    chk("legacy type", 64'(LTYPE_READ_PARITY), 64'(legacy_error_type));
    chk("legacy addr", legacy_addr_in, legacy_error_address);
    wr(REG_STATE, 64'h0);
    fire(3'h6, 1'b0, 1'b0);
    chk("bus fail abort", 64'h1, 64'(seen));
    chk("bus fail type", 64'(LTYPE_BUS_FAIL), 64'(legacy_error_type));
    rd(REG_LEGACY, v);
    chk("legacy log", {legacy_addr_in[61:0], LTYPE_BUS_FAIL}, v);
    wr(REG_STATE, 64'h0);
    fire(3'h0, 1'b0, 1'b0);
    chk("legacy masks core", 64'h0, 64'(seen));
    @(posedge sys_clk);
    legacy_mode <= 1'b0;
  endtask

  // Nested event, then a second reset
  task automatic t_nested;
    logic [63:0] v;
    fire(3'h3, 1'b1, 1'b0);
    chk("first abort", 64'h1, 64'(seen));
    fire(3'h4, 1'b0, 1'b0);
    chk("nested abort", 64'h0, 64'(seen));
    chk("shutdown", 64'h1, 64'(shutdown));
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(REG_STATE, v);
    chk("state reset", 64'h0, v);
    chk("shutdown reset", 64'h0, 64'(shutdown));
    wr(REG_ENABLE, 64'h1);
    fire(3'h1, 1'b0, 1'b1);
    chk("partial enable", 64'h1, 64'(seen));
    wr(REG_STATE, 64'h0);
    wr(REG_ENABLE, 64'h0);
    fire(3'h2, 1'b0, 1'b0);
    chk("zero enable", 64'h0, 64'(seen));
  endtask

  // Hang guard
  initial
  begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    {nrst, legacy_mode, msr_rd, msr_wr, go, rs, lk} = 7'h00;
    {kind, msr_sel, msr_wdata} = '0;
    legacy_addr_in = 64'h0000_00AB_CDEF_0123;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_after_reset();
    t_each_kind();
    t_legacy();
    t_nested();
    report_and_stop();
  end
endmodule // machine_check_global_control_tb
